//--- rtl/dcr_defines.svh
// register indices, reset values, field positions and write masks of the channel register bank
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH
`define DCR_IDX_IFC 8'h00
`define DCR_IDX_MODE_LO 8'h20
`define DCR_IDX_MODE_HI 8'h21
`define DCR_IDX_SPAN 8'h2A
`define DCR_IDX_REF 8'h3C
`define DCR_IDX_MUX 8'h93
`define DCR_IDX_STAT 8'hC2
`define DCR_IDX_HWEN 8'hD0
`define DCR_IDX_SWEN 8'hD1
`define DCR_IDX_CONV0 8'hD3
`define DCR_IDX_SCONV 8'hE3
`define DCR_IDX_SCSEL 8'hE4
`define DCR_IDX_TRIG0 8'hE5
`define DCR_IDX_SIN 8'hE7
`define DCR_IDX_SISEL 8'hE8
`define DCR_IDX_TRIG1 8'hE9
`define DCR_IDX_INP0 8'hEB
`define DCR_IDX_IRQ_STAT 8'h70
`define DCR_IDX_IRQ_MASK 8'h71
`define DCR_IDX_SPTR 8'h7E
`define DCR_IDX_SDATA 8'h7F
`define DCR_RST_IFC 8'h10
`define DCR_RST_MODE 8'hFF
`define DCR_RST_SPAN 8'h00
`define DCR_RST_REF 8'h00
`define DCR_RST_MUX 8'h00
`define DCR_RST_STAT 8'h04
`define DCR_RST_SEL 8'hFF
`define DCR_RST_CODE 16'h0000
`define DCR_MASK_IFC 8'h30
`define DCR_MASK_SPAN 8'h04
`define DCR_MASK_REF 8'h01
`define DCR_MASK_MUX 8'h1F
`define DCR_MASK_STAT 8'h0E
`define DCR_BIT_RST_HI 7
`define DCR_BIT_RST_LO 0
`define DCR_BIT_DIR 5
`define DCR_BIT_SDO 4
`define DCR_BIT_FIRE 7
`define DCR_BIT_UPD_ERR 3
`define DCR_BIT_RST_WARN 2
`define DCR_BIT_IF_ERR 1
`define DCR_IRQ_SRST 0
`define DCR_IRQ_HWLD 1
`define DCR_IRQ_SWLD 2
`define DCR_IRQ_ERR 3
`endif

//--- rtl/dcr_pkg.sv
// shared types of the channel register bank
package dcr_pkg;
	typedef logic [15:0] dcr_code_t;
	typedef logic [3:0] dcr_irq_t;
endpackage

//--- rtl/dcr_reg_bank.sv
// apb register bank of the eight-channel converter: setup, load control, per-channel codes
// Function
// - soft reset only when one write sets both trigger bits 7 and 0
// - soft reset restores all registers to defaults except first setup register and interrupt status register
// - stream accesses step the address down when bit 5 is 0, up when 1
// - serial data output enabled only while setup bit 4 is one
// - first setup register reads 0x10 after reset
// - soft load copies input to converter only for soft-load-enabled channels
// - load pin pulse updates channels selected by shared input select and pin enable
// - shared converter write updates every channel whose select bit is set
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dcr_defines.svh"
module dcr_reg_bank #(
	parameter int NCH = 8,
	parameter int CW = 16,
	parameter int AW = 12
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire logic load_pin_n,
	output var logic serial_out_enable,
	output var logic [NCH*CW-1:0] converter_code,
	output var logic [2*NCH-1:0] channel_output_mode,
	output var logic irq
);
	logic [7:0] ifc_q, mode_lo_q, mode_hi_q, span_q, ref_q, mux_q, stat_q;
	logic [7:0] hwen_q, swen_q, scsel_q, sisel_q, ptr_q;
	dcr_pkg::dcr_code_t sconv_q, sin_q;
	dcr_pkg::dcr_irq_t ist_q, imask_q;
	logic [NCH-1:0][CW-1:0] conv_q, inp_q, conv_d, inp_d;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, ld_prev_q, irq_q;

	// pstrb is not used: every register is no wider than one byte lane pair and taken whole
	wire commit = psel & penable & pready_q;
	wire sample = psel & penable & ~pready_q;
	wire [7:0] idx = paddr[9:2];
	wire via_ptr = (idx == `DCR_IDX_SDATA);
	wire [7:0] ea = via_ptr ? ptr_q : idx;
	wire wr = commit & pwrite;
	wire [CW-1:0] wd = pwdata[CW-1:0];
	wire [7:0] wb = pwdata[7:0];

	function automatic logic [NCH-1:0] ch_hit(input logic [7:0] a, input logic [7:0] base);
		logic [NCH-1:0] h;
		h = '0;
		for (int k = 0; k < NCH; k++) begin
			h[k] = (a == base + 8'(2 * k));
		end
		return h;
	endfunction

	function automatic logic [32:0] rd_word(input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		case (a)
			`DCR_IDX_IFC: r[7:0] = ifc_q;
			`DCR_IDX_MODE_LO: r[7:0] = mode_lo_q;
			`DCR_IDX_MODE_HI: r[7:0] = mode_hi_q;
			`DCR_IDX_SPAN: r[7:0] = span_q;
			`DCR_IDX_REF: r[7:0] = ref_q;
			`DCR_IDX_MUX: r[7:0] = mux_q;
			`DCR_IDX_STAT: r[7:0] = stat_q;
			`DCR_IDX_HWEN: r[7:0] = hwen_q;
			`DCR_IDX_SWEN: r[7:0] = swen_q;
			`DCR_IDX_SCONV: r[15:0] = sconv_q;
			`DCR_IDX_SCSEL: r[7:0] = scsel_q;
			`DCR_IDX_TRIG0, `DCR_IDX_TRIG1: r[7:0] = 8'h00;
			`DCR_IDX_SIN: r[15:0] = sin_q;
			`DCR_IDX_SISEL: r[7:0] = sisel_q;
			`DCR_IDX_IRQ_STAT: r[3:0] = ist_q;
			`DCR_IDX_IRQ_MASK: r[3:0] = imask_q;
			`DCR_IDX_SPTR: r[7:0] = ptr_q;
			default: begin
				r[32] = 1'b0;
				for (int k = 0; k < NCH; k++) begin
					if (a == `DCR_IDX_CONV0 + 8'(2 * k)) begin
						r = {1'b1, 16'h0000, conv_q[k]};
					end
					if (a == `DCR_IDX_INP0 + 8'(2 * k)) begin
						r = {1'b1, 16'h0000, inp_q[k]};
					end
				end
			end
		endcase
		return r;
	endfunction

	// a process, not a net: the read mux must follow register changes while the address stands
	logic [32:0] rd_now;
	always_comb begin
		rd_now = rd_word(ea);
	end
	wire ifc_wr = wr & (ea == `DCR_IDX_IFC);
	wire srst = ifc_wr & wb[`DCR_BIT_RST_HI] & wb[`DCR_BIT_RST_LO];
	wire dir_up = ifc_q[`DCR_BIT_DIR];
	wire step = commit & via_ptr;
	wire [7:0] ptr_d = (wr && idx == `DCR_IDX_SPTR) ? wb :
		step ? (dir_up ? ptr_q + 8'h01 : ptr_q - 8'h01) : ptr_q;
	wire hw_pulse = ld_prev_q & ~load_pin_n;
	wire sw_fire = wr & (ea == `DCR_IDX_TRIG0 || ea == `DCR_IDX_TRIG1) & wb[`DCR_BIT_FIRE];
	wire sconv_wr = wr & (ea == `DCR_IDX_SCONV);
	wire sin_wr = wr & (ea == `DCR_IDX_SIN);
	wire [NCH-1:0] conv_hit = ch_hit(ea, `DCR_IDX_CONV0) & {NCH{wr}};
	wire [NCH-1:0] inp_hit = ch_hit(ea, `DCR_IDX_INP0) & {NCH{wr}};
	wire [NCH-1:0] hw_ld = {NCH{hw_pulse}} & hwen_q[NCH-1:0] & sisel_q[NCH-1:0];
	wire [NCH-1:0] sw_ld = {NCH{sw_fire}} & swen_q[NCH-1:0];
	wire bad = commit & ~pslverr_q ? 1'b0 : commit & pslverr_q;
	wire [7:0] stat_set = {4'h0, hw_pulse & sw_fire, srst, bad, 1'b0};
	wire [7:0] stat_clr = (wr && ea == `DCR_IDX_STAT) ? wb & `DCR_MASK_STAT : 8'h00;
	wire [7:0] stat_d = (stat_q & ~stat_clr) | stat_set;
	wire [3:0] ist_set = {hw_pulse & sw_fire | bad, |sw_ld, |hw_ld, srst};
	wire [3:0] ist_clr = (wr && ea == `DCR_IDX_IRQ_STAT) ? wb[3:0] : 4'h0;
	wire [3:0] ist_d = (ist_q & ~ist_clr) | ist_set;

	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			// direct writes beat loads that land in the same cycle
			assign inp_d[i] = srst ? `DCR_RST_CODE : inp_hit[i] ? wd :
				(sin_wr && sisel_q[i]) ? wd : inp_q[i];
			assign conv_d[i] = srst ? `DCR_RST_CODE : conv_hit[i] ? wd :
				(sconv_wr && scsel_q[i]) ? wd :
				(hw_ld[i] || sw_ld[i]) ? inp_q[i] : conv_q[i];
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					conv_q[i] <= `DCR_RST_CODE;
					inp_q[i] <= `DCR_RST_CODE;
				end else begin
					conv_q[i] <= conv_d[i];
					inp_q[i] <= inp_d[i];
				end
			end
		end
	endgenerate

	function automatic logic [7:0] upd8(input logic [7:0] cur, input logic [7:0] a, input logic [7:0] m);
		return (wr && ea == a) ? ((pwdata[7:0] & m) | (cur & ~m)) : cur;
	endfunction

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ifc_q <= `DCR_RST_IFC;
		end else if (ifc_wr) begin
			ifc_q <= wb & `DCR_MASK_IFC;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_lo_q <= `DCR_RST_MODE;
			mode_hi_q <= `DCR_RST_MODE;
			span_q <= `DCR_RST_SPAN;
			ref_q <= `DCR_RST_REF;
			mux_q <= `DCR_RST_MUX;
			hwen_q <= `DCR_RST_SEL;
			swen_q <= `DCR_RST_SEL;
			scsel_q <= `DCR_RST_SEL;
			sisel_q <= `DCR_RST_SEL;
			sconv_q <= `DCR_RST_CODE;
			sin_q <= `DCR_RST_CODE;
			ptr_q <= 8'h00;
			imask_q <= 4'h0;
		end else if (srst) begin
			mode_lo_q <= `DCR_RST_MODE;
			mode_hi_q <= `DCR_RST_MODE;
			span_q <= `DCR_RST_SPAN;
			ref_q <= `DCR_RST_REF;
			mux_q <= `DCR_RST_MUX;
			hwen_q <= `DCR_RST_SEL;
			swen_q <= `DCR_RST_SEL;
			scsel_q <= `DCR_RST_SEL;
			sisel_q <= `DCR_RST_SEL;
			sconv_q <= `DCR_RST_CODE;
			sin_q <= `DCR_RST_CODE;
			ptr_q <= 8'h00;
			imask_q <= 4'h0;
		end else begin
			mode_lo_q <= upd8(mode_lo_q, `DCR_IDX_MODE_LO, 8'hFF);
			mode_hi_q <= upd8(mode_hi_q, `DCR_IDX_MODE_HI, 8'hFF);
			span_q <= upd8(span_q, `DCR_IDX_SPAN, `DCR_MASK_SPAN);
			ref_q <= upd8(ref_q, `DCR_IDX_REF, `DCR_MASK_REF);
			mux_q <= upd8(mux_q, `DCR_IDX_MUX, `DCR_MASK_MUX);
			hwen_q <= upd8(hwen_q, `DCR_IDX_HWEN, 8'hFF);
			swen_q <= upd8(swen_q, `DCR_IDX_SWEN, 8'hFF);
			scsel_q <= upd8(scsel_q, `DCR_IDX_SCSEL, 8'hFF);
			sisel_q <= upd8(sisel_q, `DCR_IDX_SISEL, 8'hFF);
			sconv_q <= sconv_wr ? wd : sconv_q;
			sin_q <= sin_wr ? wd : sin_q;
			ptr_q <= ptr_d;
			imask_q <= (wr && ea == `DCR_IDX_IRQ_MASK) ? wb[3:0] : imask_q;
		end
	end

	// set wins over a same-cycle write-one-to-clear
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_q <= `DCR_RST_STAT;
			ist_q <= 4'h0;
			irq_q <= 1'b0;
			ld_prev_q <= 1'b1;
		end else begin
			stat_q <= srst ? `DCR_RST_STAT : stat_d;
			ist_q <= ist_d;
			irq_q <= |(ist_q & imask_q);
			ld_prev_q <= load_pin_n;
		end
	end

	// one wait state: answer registered so every bus output comes from a flop
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= sample;
			pslverr_q <= sample & ~rd_now[32];
			prdata_q <= (sample && !pwrite) ? rd_now[31:0] : 32'h0000_0000;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign serial_out_enable = ifc_q[`DCR_BIT_SDO];
	assign converter_code = conv_q;
	assign channel_output_mode = {mode_hi_q, mode_lo_q};
	assign irq = irq_q;

	logic first_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	property p_srst_both;
		srst |=> mode_lo_q == 8'hFF && swen_q == 8'hFF && conv_q[0] == 16'h0000;
	endproperty
	a_srst_both: assert property (p_srst_both) else $error("soft reset did not restore defaults");

	property p_srst_single;
		(ifc_wr && (wb[7] ^ wb[0])) |=> $stable(swen_q) && $stable(mode_lo_q) && !$rose(ist_q[0]);
	endproperty
	a_srst_single: assert property (p_srst_single) else $error("single trigger bit reset the bank");

	property p_srst_keeps_cfg;
		srst |=> ifc_q == ($past(pwdata[7:0]) & 8'h30);
	endproperty
	a_srst_keeps_cfg: assert property (p_srst_keeps_cfg) else $error("setup register lost on soft reset");

	property p_step_down;
		(step && !dir_up && !srst) |=> ptr_q == $past(ptr_q) - 8'h01;
	endproperty
	a_step_down: assert property (p_step_down) else $error("stream pointer did not step down");

	property p_step_up;
		(step && dir_up && !srst) |=> ptr_q == $past(ptr_q) + 8'h01;
	endproperty
	a_step_up: assert property (p_step_up) else $error("stream pointer did not step up");

	property p_sdo;
		ifc_wr |=> serial_out_enable == $past(pwdata[4]);
	endproperty
	a_sdo: assert property (p_sdo) else $error("serial output enable does not follow bit 4");

	property p_reset_val;
		first_q |-> ifc_q == 8'h10 && serial_out_enable;
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("setup register not 0x10 after reset");

	property p_sw_load;
		(sw_fire && swen_q[0] && !conv_hit[0] && !sconv_wr) |=> conv_q[0] == $past(inp_q[0]);
	endproperty
	a_sw_load: assert property (p_sw_load) else $error("soft load did not copy channel 0");

	property p_sw_load_off;
		(sw_fire && !swen_q[1] && !hw_pulse && !conv_hit[1] && !sconv_wr) |=> $stable(conv_q[1]);
	endproperty
	a_sw_load_off: assert property (p_sw_load_off) else $error("soft load hit a disabled channel");

	property p_hw_load;
		(hw_pulse && hwen_q[1] && sisel_q[1] && !conv_hit[1] && !sconv_wr) |=> conv_q[1] == $past(inp_q[1]);
	endproperty
	a_hw_load: assert property (p_hw_load) else $error("load pin pulse did not update channel 1");

	property p_shared_conv;
		(sconv_wr && scsel_q[2]) |=> conv_q[2] == $past(pwdata[15:0]);
	endproperty
	a_shared_conv: assert property (p_shared_conv) else $error("shared converter write missed a channel");

	property p_reserved;
		(sample && !pwrite && ea == 8'h00) |=> (prdata & 32'hFFFF_FFCF) == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved setup bits read nonzero");
endmodule
`default_nettype wire

//--- dv/dcr_host_model.sv
// apb host controller model that reaches the register bank
`timescale 1ns/100ps
`default_nettype none
module dcr_host_model (
	input wire logic sys_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// request held until pready is seen high; the slave latency is never assumed
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- dv/dac_channel_control_register_map_test.sv
// self-checking bench of the channel register bank
`timescale 1ns/100ps
`default_nettype none
module dac_channel_control_register_map_test;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, load_pin_n, serial_out_enable, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [127:0] converter_code;
	logic [15:0] channel_output_mode;
	logic errv;
	int n_errors = 0;
	int samples_checked = 0;
	dcr_reg_bank dcr_reg_bank_inst (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .load_pin_n(load_pin_n), .serial_out_enable(serial_out_enable),
		.converter_code(converter_code), .channel_output_mode(channel_output_mode), .irq(irq));
	dcr_host_model dcr_host_model_inst (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		dcr_host_model_inst.xfer(1'b1, idx, d, rdv, errv);
	endtask
	task automatic rd(input logic [7:0] idx);
		dcr_host_model_inst.xfer(1'b0, idx, 32'h00000000, rdv, errv);
	endtask
	function automatic logic [31:0] ch(input int k);
		return {16'h0000, converter_code[16*k +: 16]};
	endfunction
	task automatic conclude;
		$display("errors %0d comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic t_reset;
		rd(8'h00);
		chk(rdv, 32'h00000010);
		chk(32'(serial_out_enable), 32'h00000001);
		rd(8'hD0);
		chk(rdv, 32'h000000FF);
		chk({16'h0000, channel_output_mode}, 32'h0000FFFF);
	endtask
	task automatic t_setup;
		wr(8'h00, 32'h0000006E);
		rd(8'h00);
		chk(rdv, 32'h00000020);
		chk(32'(serial_out_enable), 32'h00000000);
		wr(8'h00, 32'h00000010);
		// the enable flop updates at the commit edge; look one edge later
		@(posedge sys_clk);
		chk(32'(serial_out_enable), 32'h00000001);
		wr(8'h2A, 32'h000000FF);
		rd(8'h2A);
		chk(rdv, 32'h00000004);
	endtask
	task automatic t_soft;
		wr(8'h20, 32'h00000000);
		wr(8'h00, 32'h00000090);
		rd(8'h20);
		chk(rdv, 32'h00000000);
		wr(8'h00, 32'h00000011);
		rd(8'h20);
		chk(rdv, 32'h00000000);
		wr(8'h00, 32'h000000B1);
		rd(8'h20);
		chk(rdv, 32'h000000FF);
		rd(8'h00);
		chk(rdv, 32'h00000030);
		// soft reset leaves its event flag raised; mask it in, then clear it
		wr(8'h71, 32'h00000001);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), 32'h00000001);
		wr(8'h70, 32'h00000001);
		repeat (2) @(posedge sys_clk);
		chk(32'(irq), 32'h00000000);
	endtask
	task automatic t_stream;
		wr(8'h7E, 32'h000000D3);
		wr(8'h7F, 32'h00001234);
		rd(8'h7E);
		chk(rdv, 32'h000000D4);
		chk(ch(0), 32'h00001234);
		wr(8'h00, 32'h00000010);
		wr(8'h7E, 32'h000000D5);
		wr(8'h7F, 32'h00004321);
		rd(8'h7E);
		chk(rdv, 32'h000000D4);
		chk(ch(1), 32'h00004321);
	endtask
	task automatic t_loads;
		wr(8'hEB, 32'h0000AAAA);
		wr(8'hED, 32'h0000BBBB);
		wr(8'hD1, 32'h00000001);
		wr(8'hE5, 32'h00000080);
		repeat (2) @(posedge sys_clk);
		chk(ch(0), 32'h0000AAAA);
		chk(ch(1), 32'h00004321);
		wr(8'hE8, 32'h00000006);
		wr(8'hE7, 32'h0000BEEF);
		wr(8'hD0, 32'h00000002);
		@(posedge sys_clk);
		load_pin_n <= 1'b0;
		@(posedge sys_clk);
		load_pin_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(ch(1), 32'h0000BEEF);
		chk(ch(2), 32'h00000000);
		wr(8'hE4, 32'h0000000C);
		wr(8'hE3, 32'h00005A5A);
		repeat (2) @(posedge sys_clk);
		chk(ch(2), 32'h00005A5A);
		chk(ch(3), 32'h00005A5A);
		chk(ch(0), 32'h0000AAAA);
	endtask
	task automatic t_unmapped;
		rd(8'h50);
		chk(32'(errv), 32'h00000001);
		chk(rdv, 32'h00000000);
	endtask
	initial begin
		rst_b = 1'b0;
		load_pin_n = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset;
		t_setup;
		t_soft;
		t_stream;
		t_loads;
		t_unmapped;
		conclude;
	end
	// the whole run needs under two hundred cycles; this margin only catches a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		conclude;
	end
endmodule
`default_nettype wire
